// file: src/mode_status_pkg.sv
// Constants and types shared by the mode, status and gate error logic.
package mode_status_pkg;

  // Register offsets on the serial register port.
  localparam logic [7:0] PRODUCT_ID_OFFSET  = 8'h13;
  localparam logic [7:0] MODE_STATUS_OFFSET = 8'h14;

  // Identification code; the value is arbitrary.
  localparam logic [7:0] PRODUCT_ID_VALUE   = 8'h5a;

  // Value returned for any address that this block does not own.
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // Field layout of the status register.
  localparam int GATE_FLAG_BIT = 7;
  localparam int GATE_CNT_MSB  = 6;
  localparam int GATE_CNT_LSB  = 2;
  localparam int MODE_MSB      = 1;
  localparam int MODE_LSB      = 0;

  // Field widths and buffer depth.
  localparam int GATE_CNT_W = 5;
  localparam int BUF_FILL_W = 6;
  localparam int BUF_DEPTH  = 32;

  // Buffer mode code that disables the output buffer.
  localparam logic [1:0] BUF_MODE_OFF = 2'h0;

  // Cycles after reset release before the boot strap is sampled.
  localparam logic [1:0] BOOT_SETTLE_CYCLES = 2'h3;

  // Values after reset.
  localparam logic [7:0] RDATA_RESET    = 8'h00;
  localparam logic [1:0] BOOT_CNT_RESET = 2'h0;

  typedef enum logic [1:0] {
    MODE_STANDBY  = 2'b00,
    MODE_WAKE     = 2'b01,
    MODE_SLEEP    = 2'b10,
    MODE_EXTERNAL_TRIGGER_MODE = 2'b11
  } op_mode_e;

  // True for the modes in which the sensor is measuring.
  function automatic logic is_active_mode(input op_mode_e mode);
    is_active_mode = (mode != MODE_STANDBY);
  endfunction

endpackage

// file: src/buffer_track_if.sv
// Signals between the mode control and the buffer gate error tracker.
`timescale 1ns/1ps
interface buffer_track_if;
  import mode_status_pkg::*;

  logic                  sample;
  logic                  pop;
  logic                  flush;
  logic                  buf_off;
  logic                  standby_to_active;
  logic                  soft_clear;
  logic                  odr_tick;
  logic                  gate_en;
  logic                  gate_flag;
  logic [GATE_CNT_W-1:0] gate_cnt;
  logic [BUF_FILL_W-1:0] fill;

  modport ctrl (
    output sample, pop, flush, buf_off, standby_to_active, soft_clear,
    output odr_tick, gate_en,
    input  gate_flag, gate_cnt, fill
  );

  modport track (
    input  sample, pop, flush, buf_off, standby_to_active, soft_clear,
    input  odr_tick, gate_en,
    output gate_flag, gate_cnt, fill
  );
endinterface

// file: src/buffer_gate_tracker.sv
// Buffer fill count, gate overrun flag and overrun period counter.
`timescale 1ns/1ps
module buffer_gate_tracker
  import mode_status_pkg::*;
#(
  parameter int DEPTH  = BUF_DEPTH,
  parameter int FILL_W = BUF_FILL_W,
  parameter int CNT_W  = GATE_CNT_W
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clk_en,
  buffer_track_if.track   trk
);

  logic [FILL_W-1:0] fill_ff;
  logic [FILL_W-1:0] nxt_fill;
  logic              flag_ff;
  logic              nxt_flag;
  logic [CNT_W-1:0]  cnt_ff;
  logic [CNT_W-1:0]  nxt_cnt;
  logic              clear;
  logic              has_data;
  logic              store;
  logic              take;
  logic              set_err;
  logic              emptied;

  always_comb begin
    has_data = (fill_ff != '0);
    clear    = trk.flush | trk.buf_off | trk.standby_to_active |
               trk.soft_clear;
    // A gated buffer refuses a new sample until it has been emptied.
    set_err  = trk.gate_en & trk.sample & has_data &
               ~trk.buf_off;
    store    = trk.sample & ~trk.buf_off & ~set_err &
               (fill_ff < FILL_W'(DEPTH));
    take     = trk.pop & has_data;
    emptied  = take & ~store & (fill_ff == FILL_W'(1));
    if (clear) begin
      nxt_fill = '0;
    end else begin
      nxt_fill = fill_ff + FILL_W'(store) - FILL_W'(take);
    end
    // A new error wins over any clear in the same cycle.
    if (set_err) begin
      nxt_flag = 1'b1;
    end else if (clear | emptied) begin
      nxt_flag = 1'b0;
    end else begin
      nxt_flag = flag_ff;
    end
    if (set_err & ~flag_ff) begin
      nxt_cnt = '0;
    end else if (clear | emptied) begin
      nxt_cnt = '0;
    end else if (flag_ff & trk.odr_tick & (cnt_ff != '1)) begin
      nxt_cnt = cnt_ff + CNT_W'(1);
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fill_ff <= '0;
      flag_ff <= 1'b0;
      cnt_ff  <= '0;
    end else if (i_clk_en) begin
      fill_ff <= nxt_fill;
      flag_ff <= nxt_flag;
      cnt_ff  <= nxt_cnt;
    end
  end

  assign trk.fill      = fill_ff;
  assign trk.gate_flag = flag_ff;
  assign trk.gate_cnt  = cnt_ff;

endmodule

// file: src/mode_status_and_gate_error.sv
// Identification and operating-mode status registers with gate error logic.
`timescale 1ns/1ps
module mode_status_and_gate_error
  import mode_status_pkg::*;
(
  input  wire logic                  I_CLK,
  input  wire logic                  I_RESET_N,
  input  wire logic                  I_CLK_EN,
  input  wire logic                  I_SOFT_RESET,
  input  wire logic                  I_BOOT_MODE_PIN,
  input  wire logic                  I_MOTION_DETECT_BOOT,
  input  wire logic                  I_ACTIVE,
  input  wire logic                  I_SLEEP_REQ,
  input  wire logic                  I_WAKE_REQ,
  input  wire logic                  I_EXTERNAL_TRIGGER_MODE,
  input  wire logic                  I_TRIGGER_PIN,
  input  wire logic                  I_MEAS_DONE,
  input  wire logic                  I_WAKE_OUT_EN,
  input  wire logic                  I_WAKE_OUTPUT_PIN_SELECT,
  input  wire logic                  I_IRQ_PIN_POLARITY,
  input  wire logic                  I_BUF_GATE_EN,
  input  wire logic [1:0]            I_BUF_MODE,
  input  wire logic                  I_BUF_FLUSH,
  input  wire logic                  I_SAMPLE_READY,
  input  wire logic                  I_BUF_POP,
  input  wire logic                  I_ODR_TICK,
  input  wire logic                  I_REG_RD,
  input  wire logic [7:0]            I_REG_ADDR,
  output logic      [7:0]            O_REG_RDATA,
  output logic                       O_REG_RVALID,
  output logic      [1:0]            O_OPERATING_MODE_FIELD,
  output logic                       O_DEBOUNCE_CLR,
  output logic                       O_BUF_DISCARD,
  output logic      [BUF_FILL_W-1:0] O_BUF_FILL,
  output logic                       O_IRQ_PIN_ONE_OUT,
  output logic                       O_IRQ_PIN_ONE_OE_N,
  output logic                       O_IRQ_PIN_TWO_OUT,
  output logic                       O_IRQ_PIN_TWO_OE_N
);

  buffer_track_if trk_if ();

  // Pin synchronisers: boot strap and trigger input.
  logic       boot_meta_ff;
  logic       boot_sync_ff;
  logic       trig_meta_ff;
  logic       trig_sync_ff;
  logic       trig_prev_ff;
  logic       nxt_boot_meta;
  logic       nxt_boot_sync;
  logic       nxt_trig_meta;
  logic       nxt_trig_sync;
  logic       nxt_trig_prev;
  logic       trig_rise;

  always_comb begin
    nxt_boot_meta = I_BOOT_MODE_PIN;
    nxt_boot_sync = boot_meta_ff;
    nxt_trig_meta = I_TRIGGER_PIN;
    nxt_trig_sync = trig_meta_ff;
    nxt_trig_prev = trig_sync_ff;
    trig_rise     = trig_sync_ff & ~trig_prev_ff;
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      boot_meta_ff <= 1'b0;
      boot_sync_ff <= 1'b0;
      trig_meta_ff <= 1'b0;
      trig_sync_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
    end else if (I_CLK_EN) begin
      boot_meta_ff <= nxt_boot_meta;
      boot_sync_ff <= nxt_boot_sync;
      trig_meta_ff <= nxt_trig_meta;
      trig_sync_ff <= nxt_trig_sync;
      trig_prev_ff <= nxt_trig_prev;
    end
  end

  // Boot sequencing: the strap is caught once it has passed the
  // synchroniser, after reset release and after each soft reset.
  logic [1:0] boot_cnt_ff;
  logic [1:0] nxt_boot_cnt;
  logic       boot_done_ff;
  logic       nxt_boot_done;
  logic       strap_high_ff;
  logic       nxt_strap_high;
  logic       boot_now;

  always_comb begin
    boot_now       = 1'b0;
    nxt_boot_cnt   = boot_cnt_ff;
    nxt_boot_done  = boot_done_ff;
    nxt_strap_high = strap_high_ff;
    if (I_SOFT_RESET) begin
      nxt_boot_cnt  = BOOT_CNT_RESET;
      nxt_boot_done = 1'b0;
    end else if (!boot_done_ff) begin
      if (boot_cnt_ff == BOOT_SETTLE_CYCLES) begin
        boot_now       = 1'b1;
        nxt_boot_done  = 1'b1;
        nxt_strap_high = boot_sync_ff;
      end else begin
        nxt_boot_cnt = boot_cnt_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      boot_cnt_ff   <= BOOT_CNT_RESET;
      boot_done_ff  <= 1'b0;
      strap_high_ff <= 1'b0;
    end else if (I_CLK_EN) begin
      boot_cnt_ff   <= nxt_boot_cnt;
      boot_done_ff  <= nxt_boot_done;
      strap_high_ff <= nxt_strap_high;
    end
  end

  // Operating mode state machine.
  op_mode_e mode_ff;
  op_mode_e nxt_mode;
  logic     trig_allowed;

  always_comb begin
    trig_allowed = I_EXTERNAL_TRIGGER_MODE & ~strap_high_ff;
    nxt_mode     = mode_ff;
    if (I_SOFT_RESET) begin
      nxt_mode = MODE_STANDBY;
    end else if (boot_now) begin
      // A high strap boots into wake only with motion-detect boot.
      if (boot_sync_ff & I_MOTION_DETECT_BOOT) begin
        nxt_mode = MODE_WAKE;
      end else begin
        nxt_mode = MODE_STANDBY;
      end
    end else if (boot_done_ff) begin
      case (mode_ff)
        MODE_STANDBY: begin
          if (I_ACTIVE) begin
            nxt_mode = trig_allowed ? MODE_EXTERNAL_TRIGGER_MODE : MODE_WAKE;
          end
        end
        MODE_WAKE: begin
          if (!I_ACTIVE) begin
            nxt_mode = MODE_STANDBY;
          end else if (trig_allowed) begin
            // One triggered measurement, then back to waiting.
            if (I_MEAS_DONE) begin
              nxt_mode = MODE_EXTERNAL_TRIGGER_MODE;
            end
          end else if (I_SLEEP_REQ) begin
            nxt_mode = MODE_SLEEP;
          end
        end
        MODE_SLEEP: begin
          if (!I_ACTIVE) begin
            nxt_mode = MODE_STANDBY;
          end else if (I_WAKE_REQ) begin
            nxt_mode = MODE_WAKE;
          end
        end
        MODE_EXTERNAL_TRIGGER_MODE: begin
          if (!I_ACTIVE) begin
            nxt_mode = MODE_STANDBY;
          end else if (!trig_allowed) begin
            nxt_mode = MODE_WAKE;
          end else if (trig_rise) begin
            nxt_mode = MODE_WAKE;
          end
        end
        default: begin
          nxt_mode = MODE_STANDBY;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      mode_ff <= MODE_STANDBY;
    end else if (I_CLK_EN) begin
      mode_ff <= nxt_mode;
    end
  end

  // Events derived from mode changes and buffer configuration.
  logic mode_entry;
  logic sta_event;
  logic buf_off;
  logic debounce_clr_ff;
  logic nxt_debounce_clr;
  logic discard_ff;
  logic nxt_discard;

  always_comb begin
    mode_entry = (nxt_mode != mode_ff) & is_active_mode(nxt_mode);
    sta_event  = ~is_active_mode(mode_ff) & is_active_mode(nxt_mode);
    buf_off    = (I_BUF_MODE == BUF_MODE_OFF);
    nxt_debounce_clr = mode_entry;
    nxt_discard      = sta_event | buf_off | I_BUF_FLUSH |
                       I_SOFT_RESET;
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      debounce_clr_ff <= 1'b0;
      discard_ff      <= 1'b0;
    end else if (I_CLK_EN) begin
      debounce_clr_ff <= nxt_debounce_clr;
      discard_ff      <= nxt_discard;
    end
  end

  // Buffer gate tracking.
  always_comb begin
    trk_if.sample            = I_SAMPLE_READY & is_active_mode(mode_ff);
    trk_if.pop               = I_BUF_POP;
    trk_if.flush             = I_BUF_FLUSH;
    trk_if.buf_off           = buf_off;
    trk_if.standby_to_active = sta_event;
    trk_if.soft_clear        = I_SOFT_RESET;
    trk_if.odr_tick          = I_ODR_TICK;
    trk_if.gate_en           = I_BUF_GATE_EN;
  end

  buffer_gate_tracker #(
    .DEPTH  (BUF_DEPTH),
    .FILL_W (BUF_FILL_W),
    .CNT_W  (GATE_CNT_W)
  ) u_tracker (
    .i_clk     (I_CLK),
    .i_reset_n (I_RESET_N),
    .i_clk_en  (I_CLK_EN),
    .trk       (trk_if.track)
  );

  // Static wake level on the selected interrupt pin.
  logic one_out_ff;
  logic one_oe_n_ff;
  logic two_out_ff;
  logic two_oe_n_ff;
  logic nxt_one_out;
  logic nxt_one_oe_n;
  logic nxt_two_out;
  logic nxt_two_oe_n;
  logic wake_drive;

  always_comb begin
    wake_drive   = I_WAKE_OUT_EN & (mode_ff == MODE_WAKE);
    nxt_one_out  = I_IRQ_PIN_POLARITY;
    nxt_two_out  = I_IRQ_PIN_POLARITY;
    nxt_one_oe_n = ~(wake_drive & ~I_WAKE_OUTPUT_PIN_SELECT);
    nxt_two_oe_n = ~(wake_drive & I_WAKE_OUTPUT_PIN_SELECT);
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      one_out_ff  <= 1'b0;
      one_oe_n_ff <= 1'b1;
      two_out_ff  <= 1'b0;
      two_oe_n_ff <= 1'b1;
    end else if (I_CLK_EN) begin
      one_out_ff  <= nxt_one_out;
      one_oe_n_ff <= nxt_one_oe_n;
      two_out_ff  <= nxt_two_out;
      two_oe_n_ff <= nxt_two_oe_n;
    end
  end

  // Register read port; reads only sample state.
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       rvalid_ff;
  logic       nxt_rvalid;
  logic [7:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[GATE_FLAG_BIT]              = trk_if.gate_flag;
    status_word[GATE_CNT_MSB:GATE_CNT_LSB]  = trk_if.gate_cnt;
    status_word[MODE_MSB:MODE_LSB]          = mode_ff;
    nxt_rvalid = I_REG_RD;
    nxt_rdata  = rdata_ff;
    if (I_REG_RD) begin
      case (I_REG_ADDR)
        PRODUCT_ID_OFFSET: begin
          nxt_rdata = PRODUCT_ID_VALUE;
        end
        MODE_STATUS_OFFSET: begin
          nxt_rdata = status_word;
        end
        default: begin
          nxt_rdata = UNMAPPED_READ_VALUE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rdata_ff  <= RDATA_RESET;
      rvalid_ff <= 1'b0;
    end else if (I_CLK_EN) begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign O_REG_RDATA            = rdata_ff;
  assign O_REG_RVALID           = rvalid_ff;
  assign O_OPERATING_MODE_FIELD = mode_ff;
  assign O_DEBOUNCE_CLR         = debounce_clr_ff;
  assign O_BUF_DISCARD          = discard_ff;
  assign O_BUF_FILL             = trk_if.fill;
  assign O_IRQ_PIN_ONE_OUT      = one_out_ff;
  assign O_IRQ_PIN_ONE_OE_N     = one_oe_n_ff;
  assign O_IRQ_PIN_TWO_OUT      = two_out_ff;
  assign O_IRQ_PIN_TWO_OE_N     = two_oe_n_ff;

endmodule

// file: dv/mode_status_asserts.sv
// Port checker for the mode, status and gate error block.
`timescale 1ns/1ps
module mode_status_asserts
  import mode_status_pkg::*;
(
  input wire logic       I_CLK,
  input wire logic       I_RESET_N,
  input wire logic       I_CLK_EN,
  input wire logic       I_SOFT_RESET,
  input wire logic       I_SAMPLE_READY,
  input wire logic       I_BUF_POP,
  input wire logic       I_BUF_FLUSH,
  input wire logic [1:0] I_BUF_MODE,
  input wire logic       I_ODR_TICK,
  input wire logic       I_WAKE_OUT_EN,
  input wire logic       I_WAKE_OUTPUT_PIN_SELECT,
  input wire logic       I_IRQ_PIN_POLARITY,
  input wire logic       I_REG_RD,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic       O_REG_RVALID,
  input wire logic [1:0] O_OPERATING_MODE_FIELD,
  input wire logic       O_DEBOUNCE_CLR,
  input wire logic       O_BUF_DISCARD,
  input wire logic [5:0] O_BUF_FILL,
  input wire logic       O_IRQ_PIN_ONE_OUT,
  input wire logic       O_IRQ_PIN_ONE_OE_N
);
  wire       rd = I_CLK_EN && I_REG_RD;
  wire       rd14 = rd && I_REG_ADDR == MODE_STATUS_OFFSET;
  wire       quiet = I_CLK_EN && !I_SOFT_RESET && !I_SAMPLE_READY &&
                     !I_BUF_POP && !I_BUF_FLUSH && !I_ODR_TICK &&
                     I_BUF_MODE != BUF_MODE_OFF &&
                     O_OPERATING_MODE_FIELD != MODE_STANDBY;
  wire [1:0] md = O_OPERATING_MODE_FIELD;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  a_rvalid_pulse: assert property (
    rd |=> O_REG_RVALID) else $error("read gave no valid pulse");
  a_rvalid_quiet: assert property (
    I_CLK_EN && !I_REG_RD |=> !O_REG_RVALID) else $error("spurious valid");
  a_id_readback: assert property (
    rd && I_REG_ADDR == PRODUCT_ID_OFFSET |=> O_REG_RDATA == PRODUCT_ID_VALUE)
    else $error("identifier read wrong");
  a_unmapped_zero: assert property (
    rd && I_REG_ADDR != PRODUCT_ID_OFFSET && !rd14 |=> O_REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_status_mode: assert property (
    rd14 |=> O_REG_RDATA[1:0] == $past(md)) else $error("mode field wrong");
  a_read_no_side: assert property (
    rd14 && quiet ##1 rd14 |=> O_REG_RDATA[7:2] == $past(O_REG_RDATA[7:2]))
    else $error("status moved without cause");
  a_sleep_debounce: assert property (
    $changed(md) && md == MODE_SLEEP |-> O_DEBOUNCE_CLR)
    else $error("no debounce clear on sleep entry");
  a_pop_empties: assert property (
    I_CLK_EN && I_BUF_POP && O_BUF_FILL == 6'h01 && !I_SAMPLE_READY
    |=> O_BUF_FILL == 6'h00) else $error("last pop left fill");
  a_off_discards: assert property (
    I_CLK_EN && I_BUF_MODE == BUF_MODE_OFF |=> O_BUF_FILL == 6'h00 &&
    O_BUF_DISCARD) else $error("buffer off kept contents");
  a_wake_pin_one: assert property (
    (I_WAKE_OUT_EN && !I_WAKE_OUTPUT_PIN_SELECT && md == MODE_WAKE &&
    $stable(I_IRQ_PIN_POLARITY))[*2] |-> !O_IRQ_PIN_ONE_OE_N &&
    O_IRQ_PIN_ONE_OUT == I_IRQ_PIN_POLARITY) else $error("wake level wrong");

  c_gate_flag: cover property (rd14 ##1 O_REG_RDATA[7]);
  c_trig_mode: cover property (md == MODE_EXTERNAL_TRIGGER_MODE);
  c_sleep_mode: cover property (md == MODE_SLEEP);
endmodule

bind mode_status_and_gate_error mode_status_asserts u_asserts (
  .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_CLK_EN(I_CLK_EN),
  .I_SOFT_RESET(I_SOFT_RESET), .I_SAMPLE_READY(I_SAMPLE_READY),
  .I_BUF_POP(I_BUF_POP), .I_BUF_FLUSH(I_BUF_FLUSH),
  .I_BUF_MODE(I_BUF_MODE), .I_ODR_TICK(I_ODR_TICK),
  .I_WAKE_OUT_EN(I_WAKE_OUT_EN),
  .I_WAKE_OUTPUT_PIN_SELECT(I_WAKE_OUTPUT_PIN_SELECT),
  .I_IRQ_PIN_POLARITY(I_IRQ_PIN_POLARITY), .I_REG_RD(I_REG_RD),
  .I_REG_ADDR(I_REG_ADDR), .O_REG_RDATA(O_REG_RDATA),
  .O_REG_RVALID(O_REG_RVALID),
  .O_OPERATING_MODE_FIELD(O_OPERATING_MODE_FIELD),
  .O_DEBOUNCE_CLR(O_DEBOUNCE_CLR), .O_BUF_DISCARD(O_BUF_DISCARD),
  .O_BUF_FILL(O_BUF_FILL), .O_IRQ_PIN_ONE_OUT(O_IRQ_PIN_ONE_OUT),
  .O_IRQ_PIN_ONE_OE_N(O_IRQ_PIN_ONE_OE_N)
);

// file: dv/status_host.sv
// Host model that polls the block's registers over its read port.
`timescale 1ns/1ps
module status_host (
  input  wire logic       i_clk,
  input  wire logic       i_rvalid,
  input  wire logic [7:0] i_rdata,
  output logic            o_rd,
  output logic [7:0]      o_addr
);
  initial begin
    o_rd = 1'b0;
    o_addr = 8'h00;
  end

  // Two back-to-back reads; each answer is taken in the cycle it stands.
  task automatic read_pair(input logic [7:0] a, output logic [7:0] d0,
                           output logic [7:0] d1, output logic ok);
    @(negedge i_clk);
    o_rd = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    ok = i_rvalid;
    d0 = i_rdata;
    @(negedge i_clk);
    ok = ok & i_rvalid;
    d1 = i_rdata;
    o_rd = 1'b0;
    o_addr = ~a;
  endtask
endmodule

// file: dv/mode_status_and_gate_error_tb_top.sv
// Self-checking bench for the mode, status and gate error block.
`timescale 1ns/1ps
module mode_status_and_gate_error_tb_top;
  import mode_status_pkg::*;
  logic       clk, rst_n, soft_rst, strap, mot_boot, active, sleep_req;
  logic       wake_req, trig_mode, trig_pin, meas_done, wout_en, wout_sel;
  logic       pol, gate_en, flush, sample, pop, odr, rd, rvalid, dclr;
  logic       discard, p1_out, p1_oe_n, p2_out, p2_oe_n, clk_en;
  logic [1:0] buf_mode, mode;
  logic [2:0] pin;
  logic [7:0] addr, rdata;
  logic [5:0] fill;
  int         miscompares, checks, seed, n;

  mode_status_and_gate_error u_dut (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_CLK_EN(clk_en),
    .I_SOFT_RESET(soft_rst), .I_BOOT_MODE_PIN(strap),
    .I_MOTION_DETECT_BOOT(mot_boot), .I_ACTIVE(active),
    .I_SLEEP_REQ(sleep_req), .I_WAKE_REQ(wake_req),
    .I_EXTERNAL_TRIGGER_MODE(trig_mode), .I_TRIGGER_PIN(trig_pin),
    .I_MEAS_DONE(meas_done), .I_WAKE_OUT_EN(wout_en),
    .I_WAKE_OUTPUT_PIN_SELECT(wout_sel), .I_IRQ_PIN_POLARITY(pol),
    .I_BUF_GATE_EN(gate_en), .I_BUF_MODE(buf_mode), .I_BUF_FLUSH(flush),
    .I_SAMPLE_READY(sample), .I_BUF_POP(pop), .I_ODR_TICK(odr),
    .I_REG_RD(rd), .I_REG_ADDR(addr), .O_REG_RDATA(rdata),
    .O_REG_RVALID(rvalid), .O_OPERATING_MODE_FIELD(mode),
    .O_DEBOUNCE_CLR(dclr), .O_BUF_DISCARD(discard), .O_BUF_FILL(fill),
    .O_IRQ_PIN_ONE_OUT(p1_out), .O_IRQ_PIN_ONE_OE_N(p1_oe_n),
    .O_IRQ_PIN_TWO_OUT(p2_out), .O_IRQ_PIN_TWO_OE_N(p2_oe_n)
  );
  status_host u_host (
    .i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_rd(rd), .o_addr(addr)
  );

  always #2 clk = ~clk;

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask

  task automatic compare(input logic [7:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_reg(input logic [7:0] got, exp);
    compare(got, exp, "read data");
  endtask

  task automatic check_port(input logic [7:0] got, exp);
    compare(got, exp, "port");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Status byte as the host should see it; the counter saturates.
  function automatic logic [7:0] status_of(input logic f, input int c,
                                           input op_mode_e m);
    return {f, 5'(c > 31 ? 31 : c), m};
  endfunction

  task automatic wait_mode(input op_mode_e m);
    int i;
    for (i = 0; i < 40 && mode !== m; i++) begin
      tick(1);
    end
    check_port(8'(mode), 8'(m));
    if (mode !== m) begin
      give_verdict();
    end
  endtask

  task automatic read_chk(input logic [7:0] a, exp);
    logic [7:0] d0, d1;
    logic       ok;
    u_host.read_pair(a, d0, d1, ok);
    check_port(8'(ok), 8'h01);
    check_reg(d0, exp);
    check_reg(d1, exp);
  endtask

  initial begin
    {clk, rst_n, soft_rst, strap, mot_boot, active, sleep_req, wake_req} = '0;
    {trig_mode, trig_pin, meas_done, wout_en, wout_sel, pol} = '0;
    {gate_en, flush, sample, pop, odr} = '0;
    buf_mode = 2'h1;
    clk_en = 1'b1;
    seed = 70;
    tick(16);
    rst_n = 1'b1;
    tick(10);
    read_chk(PRODUCT_ID_OFFSET, PRODUCT_ID_VALUE);
    read_chk(MODE_STATUS_OFFSET, status_of(0, 0, MODE_STANDBY));
    read_chk(8'h12, UNMAPPED_READ_VALUE);
    read_chk(8'h15 + 8'($random(seed) & 63), UNMAPPED_READ_VALUE);
    active = 1'b1;
    wait_mode(MODE_WAKE);
    wout_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wout_sel = k[0];
      pol = k[1];
      tick(4);
      pin = wout_sel ? {p2_oe_n, p2_out, p1_oe_n} : {p1_oe_n, p1_out, p2_oe_n};
      check_port(8'(pin), {5'h00, 1'b0, pol, 1'b1});
    end
    wout_en = 1'b0;
    tick(4);
    check_port(8'({p1_oe_n, p2_oe_n}), 8'h03);
    // A low clock enable must hold the mode although the request drops.
    clk_en = 1'b0;
    active = 1'b0;
    tick(4);
    check_port(8'(mode), 8'(MODE_WAKE));
    active = 1'b1;
    clk_en = 1'b1;
    gate_en = 1'b1;
    for (int w = 0; w < 4; w++) begin
      n = {$random(seed)} % 40 + 1;
      pulse(sample);
      check_port(8'(fill), 8'h01);
      repeat (2) pulse(sample);
      check_port(8'(fill), 8'h01);
      repeat (n) pulse(odr);
      read_chk(MODE_STATUS_OFFSET, status_of(1, n, MODE_WAKE));
      case (w)
        0: pulse(pop);
        1: pulse(flush);
        2: begin
          buf_mode = BUF_MODE_OFF;
          tick(2);
          check_port(8'(discard), 8'h01);
          buf_mode = 2'h1;
        end
        default: begin
          active = 1'b0;
          wait_mode(MODE_STANDBY);
          read_chk(MODE_STATUS_OFFSET, status_of(1, n, MODE_STANDBY));
          active = 1'b1;
          wait_mode(MODE_WAKE);
        end
      endcase
      tick(2);
      check_port(8'(fill), 8'h00);
      read_chk(MODE_STATUS_OFFSET, status_of(0, 0, MODE_WAKE));
    end
    // The debounce clear stands one cycle, so it is looked at on entry.
    sleep_req = 1'b1;
    tick(1);
    sleep_req = 1'b0;
    wait_mode(MODE_SLEEP);
    check_port(8'(dclr), 8'h01);
    wake_req = 1'b1;
    tick(1);
    wake_req = 1'b0;
    wait_mode(MODE_WAKE);
    check_port(8'(dclr), 8'h01);
    active = 1'b0;
    wait_mode(MODE_STANDBY);
    trig_mode = 1'b1;
    active = 1'b1;
    wait_mode(MODE_EXTERNAL_TRIGGER_MODE);
    check_port(8'(dclr), 8'h01);
    for (int k = 0; k < 3; k++) begin
      tick({$random(seed)} % 5 + 1);
      trig_pin = 1'b1;
      wait_mode(MODE_WAKE);
      trig_pin = 1'b0;
      read_chk(MODE_STATUS_OFFSET, status_of(0, 0, MODE_WAKE));
      pulse(meas_done);
      wait_mode(MODE_EXTERNAL_TRIGGER_MODE);
    end
    strap = 1'b1;
    mot_boot = 1'b1;
    tick(4);
    pulse(soft_rst);
    wait_mode(MODE_WAKE);
    read_chk(MODE_STATUS_OFFSET, status_of(0, 0, MODE_WAKE));
    // With the strap high, activation must not enter trigger mode.
    active = 1'b0;
    wait_mode(MODE_STANDBY);
    active = 1'b1;
    tick(4);
    check_port(8'(mode), 8'(MODE_WAKE));
    pulse(trig_pin);
    tick(20);
    check_port(8'(mode), 8'(MODE_WAKE));
    give_verdict();
  end
endmodule
